// >>> src/emb_defines.svh
// Constants for the external memory bus sequencer
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
// Mode field encodings
`define EMB_MODE_W 3
`define EMB_MODE_MUXED_BIT 2
`define EMB_MODE_BANK_SEL 2'h2
`define EMB_MODE_ON_CHIP 2'h0
// Timing byte field positions
`define EMB_SETUP_HI 7
`define EMB_SETUP_LO 6
`define EMB_WIDTH_HI 5
`define EMB_WIDTH_LO 2
`define EMB_HOLD_HI 1
`define EMB_HOLD_LO 0
// Phase lengths in core clock periods
`define EMB_CNT_W 5
`define EMB_START_LEN 5'h01
`define EMB_TAIL_LEN 5'h03
`define EMB_OVERHEAD 5'h04
// Reset values
`define EMB_BYTE_RST 8'h00
`define EMB_PTR_RST 16'h0000
`define EMB_CNT_RST 5'h00
`define EMB_RUN_RST 8'h00
`endif

// >>> src/emb_pkg.sv
// Types shared by the external memory bus sequencer
package emb_pkg;
    typedef enum logic [2:0] {
        EMB_IDLE, EMB_START, EMB_ALEH, EMB_ALEL, EMB_SETUP, EMB_STROBE, EMB_HOLD, EMB_TAIL
    } emb_state_e;

    typedef struct packed {
        logic write;
        logic wide;
        logic [15:0] data_pointer;
        logic [7:0] indirect_addr;
        logic [7:0] wdata;
    } emb_req_s;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] ale_select;
        logic [7:0] ext_mem_timing;
        logic [7:0] ext_mem_page;
    } emb_cfg_s;
endpackage

// >>> src/emb_phase_cnt.sv
// Loadable down counter that times one bus phase
`include "emb_defines.svh"
module emb_phase_cnt #(
    parameter int CNT_W = `EMB_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // Status
    output logic zero
);
    logic [CNT_W-1:0] cnt;

    assign zero = (cnt == '0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val;
        end else if (!zero) begin
            cnt <= cnt - 1'b1;
        end
    end
endmodule

// >>> src/emb_seq.sv
// External memory bus strobe and address sequencer
// Functional notes
// - Non-muxed modes 101, 110, 111 run 16-bit moves off chip
// - Modes 101 and 111: non-muxed 8-bit moves without bank select
// - Mode 110: non-muxed 8-bit moves with bank select
// - Muxed modes 001, 010, 011 run 16-bit moves off chip
// - Modes 001 and 011: muxed 8-bit moves without bank select
// - Mode 010: muxed 8-bit moves with bank select
// - 16-bit move: upper address from pointer high, lower from pointer low
// - Setup before strobe programmable 0 to 3 clocks
// - Strobe width programmable 1 to 16 clocks
// - Address hold after strobe programmable 0 to 3 clocks
// - Muxed: latch pulse high 1 to 4 clocks
// - Muxed: latch pulse low 1 to 4 clocks before strobe
// - Write data leads strobe end by 1 to 19 clocks
// - Write data kept 0 to 3 clocks after strobe end
// - Bus routes to lower or upper ports, active only during moves
// - Move length is setup plus strobe plus hold plus four, plus latch high and latch low when muxed
// - Hold field value is hold time in clocks
// - Bank modes: 8-bit move upper address from page, lower from indirect
// - No bank: 8-bit move leaves upper address undriven
`include "emb_defines.svh"
module emb_seq #(
    parameter int CNT_W = `EMB_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration
    input wire emb_pkg::emb_cfg_s cfg,
    input wire logic use_upper_ports,
    // Request and answer
    input wire logic req_valid,
    input wire emb_pkg::emb_req_s req,
    output logic req_ready,
    output logic done,
    output logic [7:0] rdata,
    // Port group selection
    output logic bus_on_lower,
    output logic bus_on_upper,
    // External pins
    output logic [7:0] addr_hi,
    output logic addr_hi_oe,
    output logic [7:0] addr_lo,
    output logic addr_lo_oe,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic rd_n,
    output logic wr_n,
    output logic ale
);
    // ------------------------------------------------------------
    // Latched request and configuration
    // ------------------------------------------------------------
    emb_pkg::emb_state_e st;
    emb_pkg::emb_state_e next_st;
    emb_pkg::emb_req_s rq;
    emb_pkg::emb_cfg_s cf;
    logic upper;
    logic cnt_zero;
    logic load;
    logic [CNT_W-1:0] load_val;

    wire logic off_chip = (cfg.mode[1:0] != `EMB_MODE_ON_CHIP);
    wire logic accept = req_valid && (st == emb_pkg::EMB_IDLE);
    wire logic muxed = !cf.mode[`EMB_MODE_MUXED_BIT];
    wire logic bank = (cf.mode[1:0] == `EMB_MODE_BANK_SEL);
    wire logic [1:0] setup_len = cf.ext_mem_timing[`EMB_SETUP_HI:`EMB_SETUP_LO];
    wire logic [3:0] width_code = cf.ext_mem_timing[`EMB_WIDTH_HI:`EMB_WIDTH_LO];
    wire logic [1:0] hold_len = cf.ext_mem_timing[`EMB_HOLD_HI:`EMB_HOLD_LO];
    wire logic active = (st != emb_pkg::EMB_IDLE);
    wire logic addr_phase = active && (st != emb_pkg::EMB_TAIL);
    wire logic strobe = (st == emb_pkg::EMB_STROBE);

    // ------------------------------------------------------------
    // Phase order and lengths
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] phase_len(emb_pkg::emb_state_e s, emb_pkg::emb_cfg_s c);
        logic [CNT_W-1:0] len;
        len = `EMB_START_LEN;
        unique case (s)
            emb_pkg::EMB_IDLE: len = `EMB_START_LEN;
            emb_pkg::EMB_START: len = `EMB_START_LEN;
            emb_pkg::EMB_ALEH: len = CNT_W'(c.ale_select) + 1'b1;
            emb_pkg::EMB_ALEL: len = CNT_W'(c.ale_select) + 1'b1;
            emb_pkg::EMB_SETUP: len = CNT_W'(c.ext_mem_timing[`EMB_SETUP_HI:`EMB_SETUP_LO]);
            emb_pkg::EMB_STROBE: len = CNT_W'(c.ext_mem_timing[`EMB_WIDTH_HI:`EMB_WIDTH_LO]) + 1'b1;
            emb_pkg::EMB_HOLD: len = CNT_W'(c.ext_mem_timing[`EMB_HOLD_HI:`EMB_HOLD_LO]);
            emb_pkg::EMB_TAIL: len = `EMB_TAIL_LEN;
        endcase
        return len;
    endfunction

    always_comb begin
        next_st = st;
        unique case (st)
            emb_pkg::EMB_IDLE: next_st = emb_pkg::EMB_START;
            emb_pkg::EMB_START: begin
                if (muxed) begin
                    next_st = emb_pkg::EMB_ALEH;
                end else begin
                    next_st = (setup_len != 2'h0) ? emb_pkg::EMB_SETUP : emb_pkg::EMB_STROBE;
                end
            end
            emb_pkg::EMB_ALEH: next_st = emb_pkg::EMB_ALEL;
            emb_pkg::EMB_ALEL: begin
                next_st = (setup_len != 2'h0) ? emb_pkg::EMB_SETUP : emb_pkg::EMB_STROBE;
            end
            emb_pkg::EMB_SETUP: next_st = emb_pkg::EMB_STROBE;
            emb_pkg::EMB_STROBE: begin
                next_st = (hold_len != 2'h0) ? emb_pkg::EMB_HOLD : emb_pkg::EMB_TAIL;
            end
            emb_pkg::EMB_HOLD: next_st = emb_pkg::EMB_TAIL;
            emb_pkg::EMB_TAIL: next_st = emb_pkg::EMB_IDLE;
        endcase
    end

    assign load = accept || (active && cnt_zero);
    assign load_val = phase_len(accept ? emb_pkg::EMB_START : next_st, cf) - 1'b1;

    emb_phase_cnt #(
        .CNT_W(CNT_W)
    ) u_cnt (
        .clk(clk),
        .rst_b(rst_b),
        .load(load),
        .load_val(load_val),
        .zero(cnt_zero)
    );

    // ------------------------------------------------------------
    // Read data capture
    // ------------------------------------------------------------
    // Bus answers our own strobe, so data is taken on the edge that ends it
    wire logic read_end = !rd_n && !strobe;

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= emb_pkg::EMB_IDLE;
            rq <= '0;
            cf <= '0;
            upper <= 1'b0;
            rdata <= `EMB_BYTE_RST;
        end else begin
            if (accept && off_chip) begin
                st <= emb_pkg::EMB_START;
                rq <= req;
                cf <= cfg;
                upper <= use_upper_ports;
            end else if (active && cnt_zero) begin
                st <= next_st;
            end
            if (read_end) begin
                rdata <= data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Handshake and pin drive
    // ------------------------------------------------------------
    assign req_ready = !active;
    assign done = (accept && !off_chip) || ((st == emb_pkg::EMB_TAIL) && cnt_zero);
    assign bus_on_lower = active && !upper;
    assign bus_on_upper = active && upper;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_hi <= `EMB_BYTE_RST;
            addr_lo <= `EMB_BYTE_RST;
            data_out <= `EMB_BYTE_RST;
        end else begin
            addr_hi <= rq.wide ? rq.data_pointer[15:8] : cf.ext_mem_page;
            addr_lo <= rq.wide ? rq.data_pointer[7:0] : rq.indirect_addr;
            data_out <= (st == emb_pkg::EMB_ALEH) ? next_lo_addr() : rq.wdata;
        end
    end

    function automatic logic [7:0] next_lo_addr();
        return rq.wide ? rq.data_pointer[7:0] : rq.indirect_addr;
    endfunction

    wire logic wdata_phase = rq.write && (st inside {emb_pkg::EMB_SETUP, emb_pkg::EMB_STROBE,
        emb_pkg::EMB_HOLD});
    wire logic hi_driven = addr_phase && (rq.wide || bank);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_hi_oe <= 1'b0;
            addr_lo_oe <= 1'b0;
            data_oe <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ale <= 1'b0;
        end else begin
            addr_hi_oe <= hi_driven;
            addr_lo_oe <= addr_phase && !muxed;
            data_oe <= wdata_phase || (st == emb_pkg::EMB_ALEH);
            rd_n <= !(strobe && !rq.write);
            wr_n <= !(strobe && rq.write);
            ale <= (st == emb_pkg::EMB_ALEH);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] busy_run;
    logic [7:0] strobe_run;
    logic [7:0] ale_run;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_run <= `EMB_RUN_RST;
            strobe_run <= `EMB_RUN_RST;
            ale_run <= `EMB_RUN_RST;
        end else begin
            busy_run <= active ? busy_run + 1'b1 : `EMB_RUN_RST;
            strobe_run <= strobe ? strobe_run + 1'b1 : `EMB_RUN_RST;
            ale_run <= (st == emb_pkg::EMB_ALEH) ? ale_run + 1'b1 : `EMB_RUN_RST;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_move_starts: assert property (accept && off_chip |=> st == emb_pkg::EMB_START)
        else $error("Off-chip move did not start");
    a_strobe_width: assert property (strobe && cnt_zero |-> strobe_run == 8'(width_code))
        else $error("Strobe width wrong");
    a_total_len: assert property ((st == emb_pkg::EMB_TAIL) && cnt_zero |-> busy_run + 8'h01 ==
        8'(setup_len) + 8'(width_code) + 8'h01 + 8'(hold_len) + 8'(`EMB_OVERHEAD) +
        (muxed ? 8'(cf.ale_select) * 8'h02 + 8'h02 : 8'h00))
        else $error("Move length wrong");
    a_ale_high: assert property ((st == emb_pkg::EMB_ALEH) && cnt_zero |-> ale_run ==
        8'(cf.ale_select))
        else $error("Latch pulse width wrong");
    a_hi_page: assert property (addr_hi_oe && !rq.wide && bank |-> addr_hi == cf.ext_mem_page)
        else $error("Page byte not on upper address");
    a_hi_pointer: assert property (addr_hi_oe && rq.wide |-> addr_hi == rq.data_pointer[15:8])
        else $error("Pointer high byte not on upper address");
    a_hi_float: assert property (active && !rq.wide && !bank |=> !addr_hi_oe)
        else $error("Upper address driven without bank select");
    a_idle_quiet: assert property (!active && !$past(active) |-> !addr_lo_oe && !data_oe
        && rd_n && wr_n)
        else $error("Bus driven outside a move");
    a_mux_release: assert property (muxed && (st == emb_pkg::EMB_ALEL) |=> !data_oe)
        else $error("Address not released before strobe");
endmodule

// >>> verification/emb_mem_model.sv
// External memory model that answers reads from the presented address
module emb_mem_model (
    // Clock
    input wire logic clk,
    // Address, data and strobes from the sequencer
    input wire logic [7:0] addr_hi,
    input wire logic addr_hi_oe,
    input wire logic [7:0] addr_lo,
    input wire logic addr_lo_oe,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic rd_n,
    input wire logic ale,
    // Read data back to the sequencer
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lat_lo = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] hi;
    logic [7:0] lo;
    // Undriven upper byte reads as port value zero
    assign hi = addr_hi_oe ? addr_hi : 8'h00;
    assign lo = addr_lo_oe ? addr_lo : lat_lo;
    // Released bus toggles every cycle
    assign data_in = !rd_n ? (hi ^ {lo[3:0], lo[7:4]} ^ 8'hA5) : ~last;
    always_ff @(posedge clk) begin
        if (ale && data_oe) begin
            lat_lo <= data_out;
        end
        last <= data_in;
    end
endmodule

// >>> verification/emb_seq_tb.sv
// Self-checking testbench for the external memory bus sequencer
module emb_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, use_upper_ports, req_valid, req_ready, done, bus_on_lower, bus_on_upper;
    logic addr_hi_oe, addr_lo_oe, data_oe, rd_n, wr_n, ale;
    logic [7:0] rdata, addr_hi, addr_lo, data_in, data_out;
    emb_pkg::emb_cfg_s cfg;
    emb_pkg::emb_req_s req;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    emb_seq u_emb_seq (.clk, .rst_b, .cfg, .use_upper_ports, .req_valid, .req, .req_ready,
        .done, .rdata, .bus_on_lower, .bus_on_upper, .addr_hi, .addr_hi_oe, .addr_lo,
        .addr_lo_oe, .data_in, .data_out, .data_oe, .rd_n, .wr_n, .ale);
    emb_mem_model u_emb_mem_model (.clk, .addr_hi, .addr_hi_oe, .addr_lo, .addr_lo_oe,
        .data_out, .data_oe, .rd_n, .ale, .data_in);
    always #25 clk = ~clk;
    // --------------------------------
    // Checking and closing
    // --------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    // --------------------------------
    // One transfer
    // --------------------------------
    task automatic run(input int idx);
        int n, sc, ac, len, ws, wh;
        logic [7:0] lo_s, hi_s, wd_s, lo_e, hi_e;
        logic hoe, loe, doe, up_ok, imm, bank, hoe_e, rdy;
        @(negedge clk);
        req_valid = 1'b1;
        #1;
        n = 0; sc = 0; ac = 0; loe = 0; up_ok = 1; hoe = 0; doe = 0;
        ws = 0;
        wh = 0;
        rdy = 1'b0;
        lo_s = 8'h00; hi_s = 8'h00; wd_s = 8'h00;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            if (n == 0) req_valid = 1'b0;
            #1;
            n++;
            if (ale === 1'b1) ac++;
            if (ale === 1'b1 && data_oe === 1'b1) lo_s = data_out;
            if (addr_lo_oe === 1'b1) loe = 1'b1;
            if (rd_n === 1'b0 || wr_n === 1'b0) begin
                sc++;
                hi_s = addr_hi;
                hoe = addr_hi_oe;
                if (cfg.mode[2]) lo_s = addr_lo;
                up_ok &= (bus_on_upper === use_upper_ports && bus_on_lower === !use_upper_ports);
            end
            if (wr_n === 1'b0) begin
                wd_s = data_out;
                doe = data_oe;
            end
            if (data_oe === 1'b1 && wr_n === 1'b1 && ale !== 1'b1) begin
                if (sc == 0) ws++;
                else wh++;
            end
            if (req_ready !== 1'b0) rdy = 1'b1;
        end
        if (n == 0) begin
            @(negedge clk);
            req_valid = 1'b0;
        end
        imm = (cfg.mode[1:0] == 2'h0);
        bank = (cfg.mode[1:0] == 2'h2);
        hoe_e = req.wide || bank;
        hi_e = req.wide ? req.data_pointer[15:8] : (bank ? cfg.ext_mem_page : 8'h00);
        lo_e = req.wide ? req.data_pointer[7:0] : req.indirect_addr;
        len = imm ? 0 : 5 + cfg.ext_mem_timing[7:6] + cfg.ext_mem_timing[5:2]
            + cfg.ext_mem_timing[1:0] + (cfg.mode[2] ? 0 : 2 * (cfg.ale_select + 1));
        chk("length", 16'(len), 16'(n));
        chk("strobe", imm ? 16'h0000 : 16'(cfg.ext_mem_timing[5:2] + 1), 16'(sc));
        chk("ale", (imm || cfg.mode[2]) ? 16'h0000 : 16'(cfg.ale_select + 1), 16'(ac));
        if (!imm) begin
            chk("addr_lo", {8'h00, lo_e}, {8'h00, lo_s});
            chk("addr_lo_oe", {15'h0000, cfg.mode[2]}, {15'h0000, loe});
            chk("addr_hi_oe", {15'h0000, hoe_e}, {15'h0000, hoe});
            if (hoe_e) chk("addr_hi", {8'h00, hi_e}, {8'h00, hi_s});
            chk("route", 16'h0001, {15'h0000, up_ok});
            chk("busy_ready", 16'h0000, {15'h0000, rdy});
            chk("wr_setup", 16'(req.write ? cfg.ext_mem_timing[7:6] : 2'h0), 16'(ws));
            chk("wr_hold", 16'(req.write ? cfg.ext_mem_timing[1:0] : 2'h0), 16'(wh));
            if (req.write) begin
                chk("wdata", {7'h00, 1'b1, req.wdata}, {7'h00, doe, wd_s});
            end else begin
                chk("rdata", {8'h00, hi_e ^ {lo_e[3:0], lo_e[7:4]} ^ 8'hA5},
                    {8'h00, rdata});
            end
        end
        $display("test %0d mode %0d write %0d wide %0d ended", idx, cfg.mode, req.write,
            req.wide);
    endtask
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        cfg = '0;
        use_upper_ports = 1'b0;
        void'($urandom(49));
        repeat (8) @(negedge clk);
        chk("reset", 16'h0007, {9'h000, data_oe, addr_hi_oe, addr_lo_oe, ale, rd_n, wr_n,
            req_ready});
        rst_b = 1'b1;
        for (int i = 0; i < 72; i++) begin
            @(negedge clk);
            cfg = 21'($urandom);
            cfg.mode = 3'(i);
            if (i < 16) begin
                cfg.ext_mem_timing = i[3] ? 8'hFF : 8'h00;
                cfg.ale_select = i[3] ? 2'h3 : 2'h0;
            end
            req = 34'({$urandom, $urandom});
            use_upper_ports = 1'($urandom);
            run(i);
        end
        stop_test();
    end
endmodule
